// [src/amcs_pkg.sv]
// amcs_pkg: shared constants, types and decode helpers for the ADC mode
// command sequencer. Assumes a 250 MHz reference clock and a serial link
// whose frames are delimited by an active-low chip select.
package amcs_pkg;
  // ==========================================================
  // command words
  localparam logic [15:0] CMD_NOOP = 16'h0000;
  localparam logic [15:0] CMD_STANDBY = 16'h8200;
  localparam logic [15:0] CMD_PWROFF = 16'h8300;
  localparam logic [15:0] CMD_AUTO = 16'ha000;
  localparam logic [15:0] CMD_MAN_BASE = 16'hc000;
  localparam logic [15:0] CMD_MAN_STEP = 16'h0400;
  localparam logic [15:0] CMD_MAN_AUX = 16'he000;
  // ==========================================================
  // frame and channel layout
  localparam int CMD_W = 16;
  localparam logic [4:0] CMD_BITS = 5'd16;
  localparam int NUM_CH = 8;
  localparam int CH_W = 4;
  localparam int RANGE_W = 4;
  localparam logic [3:0] AUX_CH = 4'h8;
  localparam logic [3:0] RESET_CH = 4'h0;
  // ==========================================================
  // timing
  localparam int REF_CLK_MHZ = 250;
  localparam int STANDBY_WAKE_US = 20;
  localparam int PWROFF_WAKE_MS = 15;
  localparam int STANDBY_WAKE_CYC = STANDBY_WAKE_US * REF_CLK_MHZ;
  localparam int PWROFF_WAKE_CYC = PWROFF_WAKE_MS * 1000 * REF_CLK_MHZ;
  localparam int SETTLE_W = 22;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_INVALID,
    MODE_STANDBY,
    MODE_PWROFF,
    MODE_AUTO,
    MODE_MANUAL
  } amcs_mode_e;

  typedef struct packed {
    logic [CMD_W-1:0] word;
    logic toggle;
  } amcs_cmd_s;

  typedef struct packed {
    logic strobe;
    logic [CH_W-1:0] ch;
    logic [RANGE_W-1:0] range;
  } amcs_sample_s;

  // ==========================================================
  // manual channel pick decode: base plus channel times step, or aux
  function automatic logic man_ok(input logic [CMD_W-1:0] w);
    man_ok = (w == CMD_MAN_AUX) ||
             ((w[15:13] == 3'b110) && (w[9:0] == 10'h000));
  endfunction

  function automatic logic [CH_W-1:0] man_ch(input logic [CMD_W-1:0] w);
    man_ch = (w == CMD_MAN_AUX) ? AUX_CH : {1'b0, w[12:10]};
  endfunction
endpackage

// [src/amcs_sync.sv]
// amcs_sync: two-stage synchroniser for a group of level signals.
// Assumes each bit changes slowly compared to the destination clock.
`timescale 1ns/1ps
module amcs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // amcs_sync

// [src/amcs_frame_rx.sv]
// amcs_frame_rx: serial-clock side of the command path. Counts falling
// edges of the serial clock inside a frame and captures the command word.
// Assumes chip select high clears the frame and the clock may stop between
// frames; the word is handed over with a toggle and held until the next one.
`timescale 1ns/1ps
module amcs_frame_rx (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sys_rst,
  input wire logic i_sdi,
  output amcs_pkg::amcs_cmd_s o_cmd
);
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [amcs_pkg::CMD_W-2:0] shift;
  logic [amcs_pkg::CMD_W-2:0] next_shift;
  amcs_pkg::amcs_cmd_s next_cmd;

  // ==========================================================
  // bit counter and shifter; nothing taken after the last command bit
  always_comb
  begin
    next_cnt = cnt;
    next_shift = shift;
    next_cmd = o_cmd;
    if (cnt < amcs_pkg::CMD_BITS)
    begin
      next_cnt = cnt + 5'd1;
      next_shift = {shift[amcs_pkg::CMD_W-3:0], i_sdi};
      if (cnt == amcs_pkg::CMD_BITS - 5'd1)
      begin
        next_cmd.word = {shift, i_sdi};
        next_cmd.toggle = ~o_cmd.toggle;
      end
    end
  end

  // chip select high restarts the count for the next frame
  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      cnt <= '0;
      shift <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      shift <= next_shift;
    end
  end

  // held word survives the end of the frame
  always_ff @(negedge i_sclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_cmd <= '0;
    else
      o_cmd <= next_cmd;
  end

  // same-edge check: history-based forms would reach back into the last frame
  a_cmd_on_16th: assert property (
    @(negedge i_sclk) disable iff (i_cs_n || i_sys_rst)
    (next_cmd.toggle != o_cmd.toggle) == (cnt == amcs_pkg::CMD_BITS - 5'd1))
    else $error("command word taken on a wrong serial clock edge");
endmodule // amcs_frame_rx

// [src/amcs_top.sv]
// amcs_top: command and mode sequencer of a multichannel SAR converter.
// Assumes the host is an SPI master; scan enables and range settings come
// from the program register block, which lives elsewhere.
`timescale 1ns/1ps
module amcs_top #(
  parameter int STANDBY_WAKE_CYC = amcs_pkg::STANDBY_WAKE_CYC,
  parameter int PWROFF_WAKE_CYC = amcs_pkg::PWROFF_WAKE_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_SDI,
  input wire logic I_REFERENCE_SELECT_INPUT,
  input wire logic I_HW_PD,
  input wire logic [amcs_pkg::NUM_CH-1:0] I_SEQ_EN,
  input wire logic [(amcs_pkg::NUM_CH+1)*amcs_pkg::RANGE_W-1:0] I_RANGE_CFG,
  output amcs_pkg::amcs_mode_e O_MODE,
  output logic O_STANDBY,
  output logic O_POWER_OFF,
  output logic O_REF_ON,
  output logic O_SDO_INVALID,
  output logic O_SETTLING,
  output logic O_CFG_DEFAULT,
  output logic [amcs_pkg::CH_W-1:0] O_ALARM_CH,
  output amcs_pkg::amcs_sample_s O_SAMPLE
);
  amcs_pkg::amcs_cmd_s link_cmd;
  logic [3:0] sync_out;
  logic cs_n_s, tog_s, reference_select_input_s, hw_pd_s;
  logic cs_n_q, tog_q, hw_pd_q;
  logic cs_fall, cs_rise, got_edge;
  logic frame_open, cmd_got, next_frame_open, next_cmd_got;
  logic [amcs_pkg::CMD_W-1:0] cmd_word, next_cmd_word, word_now;
  logic commit, abort;
  amcs_pkg::amcs_mode_e next_mode;
  logic restart, next_restart;
  logic [amcs_pkg::CH_W-1:0] man_sel, next_man_sel;
  logic [amcs_pkg::SETTLE_W-1:0] settle, next_settle;
  logic next_cfg_default;
  logic [amcs_pkg::CH_W-1:0] next_alarm_ch;
  amcs_pkg::amcs_sample_s next_sample;

  // ==========================================================
  // link side: serial clock domain
  amcs_frame_rx u_rx (
    .i_sclk(I_SCLK),
    .i_cs_n(I_CS_N),
    .i_sys_rst(I_SYS_RST),
    .i_sdi(I_SDI),
    .o_cmd(link_cmd)
  );

  // pins and the handover toggle cross on two flops each
  amcs_sync #(.W(4)) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_d({~I_CS_N, link_cmd.toggle, I_REFERENCE_SELECT_INPUT, I_HW_PD}),
    .o_q(sync_out)
  );
  // select crosses inverted so reset leaves it deselected: no false edge after reset
  assign {cs_n_s, tog_s, reference_select_input_s, hw_pd_s} = {~sync_out[3], sync_out[2:0]};

  // ==========================================================
  // edge detection on synchronised levels
  assign cs_fall = cs_n_q & ~cs_n_s;
  assign cs_rise = ~cs_n_q & cs_n_s;
  assign got_edge = tog_s ^ tog_q;
  // word is held steady for a whole frame, so it is safe once the toggle lands
  assign word_now = got_edge ? link_cmd.word : cmd_word;
  assign commit = cs_rise & frame_open & (cmd_got | got_edge);
  assign abort = cs_rise & frame_open & ~(cmd_got | got_edge);

  // ==========================================================
  // frame tracking; the arriving word wins over the clear at frame start
  always_comb
  begin
    next_frame_open = frame_open;
    next_cmd_got = cmd_got;
    next_cmd_word = cmd_word;
    if (cs_fall)
    begin
      next_frame_open = 1'b1;
      next_cmd_got = 1'b0;
    end
    if (cs_rise)
    begin
      next_frame_open = 1'b0;
      next_cmd_got = 1'b0;
    end
    if (got_edge)
    begin
      next_cmd_got = ~cs_rise;
      next_cmd_word = link_cmd.word;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      cs_n_q <= 1'b1;
      tog_q <= 1'b0;
      hw_pd_q <= 1'b0;
      frame_open <= 1'b0;
      cmd_got <= 1'b0;
      cmd_word <= amcs_pkg::CMD_NOOP;
    end
    else
    begin
      cs_n_q <= cs_n_s;
      tog_q <= tog_s;
      hw_pd_q <= hw_pd_s;
      frame_open <= next_frame_open;
      cmd_got <= next_cmd_got;
      cmd_word <= next_cmd_word;
    end
  end

  // ==========================================================
  // next enabled channel above the current one, else wrap to the lowest
  function automatic logic [amcs_pkg::CH_W-1:0] scan_next(
    input logic [amcs_pkg::NUM_CH-1:0] en,
    input logic [amcs_pkg::CH_W-1:0] cur,
    input logic from_start
  );
    logic hit;
    logic [amcs_pkg::CH_W-1:0] r;
    int i;
    hit = 1'b0;
    r = cur;
    // second lap of the loop is the wrap to the lowest enabled channel
    for (int k = 0; k < 2 * amcs_pkg::NUM_CH; k++)
    begin
      i = k % amcs_pkg::NUM_CH;
      if (!hit && en[i] && (from_start || k >= amcs_pkg::NUM_CH || i > int'(cur)))
      begin
        r = i[amcs_pkg::CH_W-1:0];
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // ==========================================================
  // mode machine; hardware power-down overrides the command path
  always_comb
  begin
    next_mode = O_MODE;
    next_restart = restart;
    next_man_sel = man_sel;
    next_cfg_default = 1'b0;
    next_settle = (settle != '0) ? settle - 1'b1 : settle;
    if (hw_pd_s)
      next_mode = amcs_pkg::MODE_PWROFF;
    else if (hw_pd_q)
    begin
      next_mode = amcs_pkg::MODE_IDLE;
      next_cfg_default = 1'b1;
    end
    else if (abort)
      next_mode = amcs_pkg::MODE_INVALID;
    else if (commit)
    begin
      if (word_now == amcs_pkg::CMD_STANDBY)
        next_mode = amcs_pkg::MODE_STANDBY;
      else if (word_now == amcs_pkg::CMD_PWROFF)
        next_mode = amcs_pkg::MODE_PWROFF;
      else if (word_now == amcs_pkg::CMD_AUTO)
      begin
        next_mode = amcs_pkg::MODE_AUTO;
        next_restart = 1'b1;
      end
      else if (amcs_pkg::man_ok(word_now))
      begin
        next_mode = amcs_pkg::MODE_MANUAL;
        next_man_sel = amcs_pkg::man_ch(word_now);
      end
      else if (word_now == amcs_pkg::CMD_NOOP)
        next_mode = O_MODE;
      else if (O_MODE == amcs_pkg::MODE_INVALID)
        next_mode = amcs_pkg::MODE_IDLE;
      // other words keep standby and power-off until a scan command
      // wake timers; configuration is never reset by a software wake
      if (O_MODE == amcs_pkg::MODE_STANDBY &&
          (next_mode == amcs_pkg::MODE_AUTO || next_mode == amcs_pkg::MODE_MANUAL))
        next_settle = amcs_pkg::SETTLE_W'(STANDBY_WAKE_CYC);
      if (O_MODE == amcs_pkg::MODE_PWROFF &&
          (next_mode == amcs_pkg::MODE_AUTO || next_mode == amcs_pkg::MODE_MANUAL))
        next_settle = !reference_select_input_s ? amcs_pkg::SETTLE_W'(PWROFF_WAKE_CYC)
                                : amcs_pkg::SETTLE_W'(STANDBY_WAKE_CYC);
    end
    if (cs_fall && O_MODE == amcs_pkg::MODE_AUTO)
      next_restart = 1'b0;
  end

  // ==========================================================
  // sampling at each frame start in auto and manual modes; the alarm follows the last sampled channel
  always_comb
  begin
    next_alarm_ch = O_ALARM_CH;
    next_sample = '0;
    if (cs_fall && (O_MODE == amcs_pkg::MODE_AUTO || O_MODE == amcs_pkg::MODE_MANUAL))
    begin
      next_sample.strobe = 1'b1;
      if (O_MODE == amcs_pkg::MODE_AUTO)
        next_sample.ch = scan_next(I_SEQ_EN, O_ALARM_CH, restart);
      else
        next_sample.ch = man_sel;
      next_sample.range = I_RANGE_CFG[next_sample.ch*amcs_pkg::RANGE_W +:
                                      amcs_pkg::RANGE_W];
      next_alarm_ch = next_sample.ch;
    end
  end

  // state and decoded outputs all come from flops
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_MODE <= amcs_pkg::MODE_IDLE;
      restart <= 1'b1;
      man_sel <= amcs_pkg::RESET_CH;
      settle <= '0;
      O_STANDBY <= 1'b0;
      O_POWER_OFF <= 1'b0;
      O_REF_ON <= 1'b1;
      O_SDO_INVALID <= 1'b1;
      O_SETTLING <= 1'b0;
      O_CFG_DEFAULT <= 1'b0;
      O_ALARM_CH <= amcs_pkg::RESET_CH;
      O_SAMPLE <= '0;
    end
    else
    begin
      O_MODE <= next_mode;
      restart <= next_restart;
      man_sel <= next_man_sel;
      settle <= next_settle;
      O_STANDBY <= next_mode == amcs_pkg::MODE_STANDBY;
      O_POWER_OFF <= next_mode == amcs_pkg::MODE_PWROFF;
      O_REF_ON <= next_mode != amcs_pkg::MODE_PWROFF;
      // no conversion runs outside the two scan modes
      O_SDO_INVALID <= next_mode != amcs_pkg::MODE_AUTO &&
                       next_mode != amcs_pkg::MODE_MANUAL;
      O_SETTLING <= next_settle != '0;
      O_CFG_DEFAULT <= next_cfg_default;
      O_ALARM_CH <= next_alarm_ch;
      O_SAMPLE <= next_sample;
    end
  end

  // ==========================================================
  // checks
  a_abort_invalid: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    abort && !hw_pd_s && !hw_pd_q |=> O_MODE == amcs_pkg::MODE_INVALID && O_SDO_INVALID)
    else $error("aborted frame did not reach invalid state");

  a_mode_frame_end: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !cs_rise && !hw_pd_s && !hw_pd_q |=> $stable(O_MODE))
    else $error("mode changed outside a frame end");

  a_standby_entry: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    commit && word_now == amcs_pkg::CMD_STANDBY && !hw_pd_s && !hw_pd_q
    |=> O_STANDBY && O_REF_ON && O_SDO_INVALID)
    else $error("standby not entered or reference lost");

  a_pwroff_entry: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    commit && word_now == amcs_pkg::CMD_PWROFF && !hw_pd_q
    |=> O_POWER_OFF && !O_REF_ON && !O_STANDBY)
    else $error("power-off not entered");

  a_alarm_hold: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    O_MODE == amcs_pkg::MODE_INVALID |=> $stable(O_ALARM_CH))
    else $error("alarm channel moved while invalid");

  a_noop_keep: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    commit && word_now == amcs_pkg::CMD_NOOP && !hw_pd_s && !hw_pd_q
    |=> $stable(O_MODE) && $stable(man_sel))
    else $error("all-zero command changed the mode");

  a_wake_settle: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    commit && O_MODE == amcs_pkg::MODE_PWROFF && !reference_select_input_s && !hw_pd_s &&
    !hw_pd_q && (word_now == amcs_pkg::CMD_AUTO || amcs_pkg::man_ok(word_now))
    |=> O_SETTLING [*8])
    else $error("wake from power-off did not settle");

  a_auto_restart: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    cs_fall && O_MODE == amcs_pkg::MODE_AUTO && restart && I_SEQ_EN != '0
    |-> I_SEQ_EN[next_sample.ch[2:0]] &&
    (I_SEQ_EN & ((8'h01 << next_sample.ch[2:0]) - 8'h01)) == '0 ##1 O_SAMPLE.strobe)
    else $error("auto scan did not restart at lowest channel");

  a_manual_pick: assert property (
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    O_MODE == amcs_pkg::MODE_MANUAL && cs_fall |=> O_SAMPLE.strobe && O_SAMPLE.ch == man_sel)
    else $error("manual channel not sampled");
endmodule // amcs_top

// [testbench/amcs_host_model.sv]
// amcs_host_model: host controller model that drives the serial command link.
// Assumes the device takes data bits on falling serial clock edges.
`timescale 1ns/1ps
module amcs_host_model #(
  parameter int HALF_NS = 16,
  parameter int GAP_NS = 120
) (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  // ==========================================================
  // idle levels: clock stands still high between frames
  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  // ==========================================================
  // one frame; fewer than 16 bits aborts it on purpose
  task automatic send(input logic [15:0] word, input int nbits);
    int i;
    #3;
    o_cs_n = 1'b0;
    #HALF_NS;
    for (i = 0; i < nbits; i++)
    begin
      o_sdi = (i < 16) ? word[15-i] : 1'b0;
      #HALF_NS;
      o_sclk = 1'b0;
      #HALF_NS;
      o_sclk = 1'b1;
    end
    #HALF_NS;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi; // released line must not look held
    #GAP_NS;
  endtask
endmodule // amcs_host_model

// [testbench/tb.sv]
// tb: self-checking bench for the mode command sequencer.
// Assumes a 250 MHz reference clock and shortened wake counts.
`timescale 1ns/1ps
module tb;
  localparam int SB_CYC = 20;
  localparam int PO_CYC = 40;
  logic ref_clk, sys_rst, sclk, cs_n, sdi, reference_select_input, hw_pd;
  logic [7:0] seq_en;
  logic [35:0] range_cfg;
  amcs_pkg::amcs_mode_e mode;
  logic standby, power_off, ref_on, sdo_inv, settling, cfg_def;
  logic [3:0] alarm_ch;
  amcs_pkg::amcs_sample_s sample;
  int error_cnt, n_compared, run, last_run, cfg_pulses, n, r, j;
  logic [15:0] seed;
  logic [3:0] cur;
  logic [7:0] smp_q[$];

  amcs_top #(.STANDBY_WAKE_CYC(SB_CYC), .PWROFF_WAKE_CYC(PO_CYC)) dut_u (
    .I_REF_CLK(ref_clk), .I_SYS_RST(sys_rst), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_SDI(sdi), .I_REFERENCE_SELECT_INPUT(reference_select_input), .I_HW_PD(hw_pd), .I_SEQ_EN(seq_en),
    .I_RANGE_CFG(range_cfg), .O_MODE(mode), .O_STANDBY(standby),
    .O_POWER_OFF(power_off), .O_REF_ON(ref_on), .O_SDO_INVALID(sdo_inv),
    .O_SETTLING(settling), .O_CFG_DEFAULT(cfg_def), .O_ALARM_CH(alarm_ch),
    .O_SAMPLE(sample));
  amcs_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

  // ==========================================================
  // expectation helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // next enabled channel above cur, wrapping to the lowest
  function automatic logic [3:0] next_ch(input logic [7:0] en, input logic [3:0] c,
                                         input logic first);
    int k;
    logic found;
    next_ch = c;
    found = 1'b0;
    for (k = 7; k >= 0; k--)
      if (en[k] && (first || k > c))
      begin
        next_ch = 4'(k);
        found = 1'b1;
      end
    if (!found)
      for (k = 7; k >= 0; k--)
        if (en[k])
          next_ch = 4'(k);
  endfunction

  // ==========================================================
  // compare tasks and closing
  task automatic chk_mode(input amcs_pkg::amcs_mode_e exp);
    n_compared++;
    if (mode !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, mode, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // stimulus helpers
  task automatic cmd(input logic [15:0] w, input int nb);
    host_u.send(w, nb);
  endtask

  // one strobe expected per frame; pop it and check channel and range
  task automatic take(input logic [3:0] ch);
    chk_val(smp_q.size(), 1);
    if (smp_q.size() > 0)
      chk_val(smp_q.pop_front(), {ch, range_cfg[4*ch +: 4]});
  endtask

  task automatic set_rand();
    @(posedge ref_clk);
    seed = lfsr(seed);
    seq_en <= (seed[7:0] == 8'h00) ? 8'h80 : seed[7:0];
    range_cfg <= {seed[3:0], seed, ~seed};
    @(posedge ref_clk);
  endtask

  task automatic wait_settle();
    int k;
    for (k = 0; k < 400 && settling !== 1'b0; k++)
      @(posedge ref_clk);
    @(posedge ref_clk);
  endtask

  // ==========================================================
  // clock, watchdog and output monitor
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // generous span: about sixty frames of under two microseconds each
  initial
  begin
    #300000;
    chk_val(32'h0, 32'h1);
    end_sim();
  end

  always @(posedge ref_clk)
  begin
    if (sample.strobe === 1'b1)
      smp_q.push_back({sample.ch, sample.range});
    if (settling === 1'b1)
      run++;
    else
    begin
      if (run != 0)
        last_run = run;
      run = 0;
    end
    if (cfg_def === 1'b1)
      cfg_pulses++;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    reference_select_input = 1'b0;
    hw_pd = 1'b0;
    seq_en = 8'h05;
    range_cfg = 36'h0;
    seed = 16'h0058;
    error_cnt = 0;
    n_compared = 0;
    run = 0;
    last_run = 0;
    cfg_pulses = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_mode(amcs_pkg::MODE_IDLE);
    chk_val(sdo_inv, 1'b1);
    set_rand();
    chk_mode(amcs_pkg::MODE_IDLE);
    for (n = 0; n < 9; n++)
    begin
      cmd((n == 8) ? 16'he000 : 16'hc000 + 16'(n) * 16'h0400, 34);
      chk_mode(amcs_pkg::MODE_MANUAL);
      smp_q.delete();
      cmd(16'h0000, 16);
      take(4'(n));
      chk_val(alarm_ch, n);
    end
    $display("test manual picks done");
    cmd(16'hc400, 34);
    cmd(16'h0000, 16);
    cmd(16'h8200, 8);
    chk_mode(amcs_pkg::MODE_INVALID);
    chk_val(sdo_inv, 1'b1);
    chk_val(alarm_ch, 4'h1);
    cmd(16'h0000, 16);
    chk_mode(amcs_pkg::MODE_INVALID);
    cmd(16'h8500, 16);
    chk_mode(amcs_pkg::MODE_IDLE);
    $display("test abort done");
    cmd(16'h8200, 16);
    chk_mode(amcs_pkg::MODE_STANDBY);
    chk_val({standby, ref_on}, 2'b11);
    smp_q.delete();
    cmd(16'h0000, 16);
    cmd(16'h8500, 16);
    cmd(16'h0000, 32);
    chk_mode(amcs_pkg::MODE_STANDBY);
    chk_val(sdo_inv, 1'b1);
    chk_val(smp_q.size(), 0);
    cmd(16'ha000, 34);
    chk_mode(amcs_pkg::MODE_AUTO);
    wait_settle();
    chk_val(last_run, SB_CYC);
    chk_val(cfg_pulses, 0);
    smp_q.delete();
    cmd(16'h0000, 16);
    take(next_ch(seq_en, 4'h0, 1'b1));
    $display("test standby done");
    for (r = 0; r < 3; r++)
    begin
      set_rand();
      cmd(16'ha000, 34);
      chk_mode(amcs_pkg::MODE_AUTO);
      smp_q.delete();
      cur = next_ch(seq_en, 4'h0, 1'b1);
      for (j = 0; j < 5; j++)
      begin
        cmd(16'h0000, 16);
        take(cur);
        cur = next_ch(seq_en, cur, 1'b0);
      end
      cmd(16'ha000, 16);
      smp_q.delete();
      cmd(16'h0000, 16);
      take(next_ch(seq_en, 4'h0, 1'b1));
    end
    $display("test auto scan done");
    cmd(16'h8300, 16);
    chk_mode(amcs_pkg::MODE_PWROFF);
    chk_val({power_off, ref_on}, 2'b10);
    cmd(16'h0000, 16);
    chk_mode(amcs_pkg::MODE_PWROFF);
    cmd(16'hc800, 34);
    chk_mode(amcs_pkg::MODE_MANUAL);
    wait_settle();
    chk_val(last_run, PO_CYC);
    chk_val(cfg_pulses, 0);
    @(posedge ref_clk);
    hw_pd <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk_mode(amcs_pkg::MODE_PWROFF);
    hw_pd <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk_mode(amcs_pkg::MODE_IDLE);
    chk_val(cfg_pulses, 1);
    reference_select_input <= 1'b1;
    cmd(16'h8300, 16);
    chk_mode(amcs_pkg::MODE_PWROFF);
    cmd(16'ha000, 34);
    chk_mode(amcs_pkg::MODE_AUTO);
    wait_settle();
    chk_val(last_run, SB_CYC);
    $display("test power off done");
    end_sim();
  end
endmodule // tb
